// ===== common/fan_ctrl_pkg.sv
package fan_ctrl_pkg;
	localparam int NUM_FANS     = 3;
	localparam int NUM_SENSORS  = 8;
	localparam int TEMP_W       = 8;
	localparam int RPM_W        = 16;
	localparam int DUTY_W       = 7;
	localparam int CNT_W        = 32;
	// duty cycle in percent
	localparam logic [DUTY_W-1:0] DUTY_FULL  = 7'h64;
	localparam logic [DUTY_W-1:0] DUTY_FLOOR = 7'h28;
	localparam logic [DUTY_W-1:0] DUTY_SPAN  = 7'h3C;
	// temperatures in whole degrees C
	localparam logic [TEMP_W-1:0] FULL_TEMP_MIN = 8'h19;
	localparam logic [TEMP_W-1:0] FULL_TEMP_MAX = 8'h41;
	localparam logic [TEMP_W-1:0] FULL_TEMP_RST = 8'h32;
	localparam logic [TEMP_W-1:0] RAMP_WIDTH    = 8'h19;
	// default minimum speed
	localparam logic [RPM_W-1:0] MIN_RPM_TWO_FAN   = 16'h0384;
	localparam logic [RPM_W-1:0] MIN_RPM_THREE_FAN = 16'h04B0;
	localparam logic             ALARM_EN_RST      = 1'b1;
	// rpm measurement: 1 s gate window, 2 tach pulses per rev
	localparam int CLK_HZ          = 100_000_000;
	localparam int GATE_MS         = 1000;
	localparam int GATE_CYCLES     = CLK_HZ / 1000 * GATE_MS;
	localparam int PULSES_PER_REV  = 2;
	localparam int RPM_SCALE       = 60 / PULSES_PER_REV;
	localparam int PWM_PRESCALE    = 40;
endpackage

// ===== hdl/fan_tach_meter.sv
`timescale 1ns/1ps
module fan_tach_meter
	import fan_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             ce,
	// tach pulse (synchronised) and gate
	input  wire logic             tach_sync,
	input  wire logic             gate,
	// result
	output logic [RPM_W-1:0]      rpm_q
);
	logic             tach_prev_q;
	logic [RPM_W-1:0] count_q;
	wire              tach_rise = tach_sync & ~tach_prev_q;
	wire [31:0]       rpm_wide  = 32'(count_q) * 32'(RPM_SCALE);
	wire [RPM_W-1:0]  count_d   = gate ? RPM_W'(tach_rise) :
		(count_q == '1 ? count_q : count_q + RPM_W'(tach_rise));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tach_prev_q <= 1'b0;
			count_q     <= '0;
			rpm_q       <= '0;
		end else if (ce) begin
			tach_prev_q <= tach_sync;
			count_q     <= count_d;
			if (gate)
				rpm_q <= (rpm_wide > 32'h0000FFFF) ? '1 : rpm_wide[RPM_W-1:0];
		end
	end
endmodule

// ===== hdl/fan_speed_control_monitor.sv
// Function
// R1: each fan's speed is measured in rpm and the alarm rises when any is below the threshold.
// R2: full speed is a 100% duty cycle on the fan supply.
// R3: in auto mode below full-speed temperature the duty is under 100%, proportional to margin.
// R4: duty never falls below 40%.
// R5: the threshold loads 900 rpm for two fans or 1200 rpm for three at power-on.
// R6: selector switch in high forces 100% duty.
// R7: in auto the hottest of the eight sensors drives the duty with the full-speed setting.
// R8: the full-speed temperature accepts 25 to 65 degrees in 1 degree steps.
// R9: the full-speed temperature defaults to 50 degrees.
// R10: the ramp starts 25 degrees below the full-speed temperature.
// R11: drive is an open-loop function of temperature, no regulation.
// R12: alarm generation is gated by a software enable.
// R13: an alarm-occurred flag is readable and cleared by an explicit clear.
// R14: a fan that stops completely shuts the chassis down.
// R15: ramp is linear from 40% to 100%, saturating above full-speed temperature.
// R16: the alarm flag latches and re-sets if the low speed persists after clear.
`timescale 1ns/1ps
module fan_speed_control_monitor
	import fan_ctrl_pkg::*;
#(
	parameter int GATE_LEN = GATE_CYCLES
)(
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rstn,
	input  wire logic                          ce,
	// chassis straps and rear switch
	input  wire logic                          three_fan,
	input  wire logic                          fan_high,
	// sensors and tach pins
	input  wire logic [NUM_SENSORS*TEMP_W-1:0] sensor_temp,
	input  wire logic [NUM_FANS-1:0]           tach_in,
	// software settings
	input  wire logic                          full_temp_wr,
	input  wire logic [TEMP_W-1:0]             full_temp_wdata,
	input  wire logic                          min_speed_wr,
	input  wire logic [RPM_W-1:0]              min_speed_wdata,
	input  wire logic                          alarm_enable,
	input  wire logic                          alarm_clear,
	// status
	output logic [TEMP_W-1:0]                  full_speed_temperature_q,
	output logic [RPM_W-1:0]                   min_speed_threshold_q,
	output logic [NUM_FANS*RPM_W-1:0]          fan_rpm_q,
	output logic [DUTY_W-1:0]                  duty_q,
	output logic                               alarm_q,
	output logic                               alarm_occurred_q,
	output logic                               shutdown_q,
	// fan drive
	output logic [NUM_FANS-1:0]                fan_pwm_q
);
	typedef enum logic [1:0] {ST_SYNC_A, ST_SYNC_B, ST_INIT, ST_RUN} init_t;
	init_t state_q;

	// pin synchronisers
	logic [NUM_SENSORS*TEMP_W-1:0] temp_s1_q, temp_s2_q;
	logic [NUM_FANS-1:0]           tach_s1_q, tach_s2_q;
	logic                          high_s1_q, high_s2_q;
	logic                          strap_s1_q, strap_s2_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			temp_s1_q  <= '0;
			temp_s2_q  <= '0;
			tach_s1_q  <= '0;
			tach_s2_q  <= '0;
			high_s1_q  <= 1'b0;
			high_s2_q  <= 1'b0;
			strap_s1_q <= 1'b0;
			strap_s2_q <= 1'b0;
		end else if (ce) begin
			temp_s1_q  <= sensor_temp;
			temp_s2_q  <= temp_s1_q;
			tach_s1_q  <= tach_in;
			tach_s2_q  <= tach_s1_q;
			high_s1_q  <= fan_high;
			high_s2_q  <= high_s1_q;
			strap_s1_q <= three_fan;
			strap_s2_q <= strap_s1_q;
		end
	end

	// hottest sensor
	logic [TEMP_W-1:0] hot_chain [NUM_SENSORS+1];
	assign hot_chain[0] = '0;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SENSORS; gi++) begin : g_max
			wire [TEMP_W-1:0] t = temp_s2_q[gi*TEMP_W +: TEMP_W];
			assign hot_chain[gi+1] = (t > hot_chain[gi]) ? t : hot_chain[gi]; // [R7]
		end
	endgenerate
	wire [TEMP_W-1:0] hottest = hot_chain[NUM_SENSORS];

	// open-loop duty curve: pure function of temperature and setting [R11]
	wire [TEMP_W:0]   ramp_start = {1'b0, full_speed_temperature_q} - {1'b0, RAMP_WIDTH}; // [R10]
	wire              below_ramp = {1'b0, hottest} <= ramp_start;
	wire              above_full = hottest >= full_speed_temperature_q;
	wire [TEMP_W-1:0] over_start = TEMP_W'({1'b0, hottest} - ramp_start);
	wire [15:0]       ramp_prod  = 16'(over_start) * 16'(DUTY_SPAN);
	wire [15:0]       ramp_add   = ramp_prod / 16'(RAMP_WIDTH); // [R3] [R15]
	wire [DUTY_W-1:0] auto_duty  = below_ramp ? DUTY_FLOOR : // [R4]
		above_full ? DUTY_FULL : DUTY_FLOOR + DUTY_W'(ramp_add); // [R15]
	wire [DUTY_W-1:0] duty_d     = high_s2_q ? DUTY_FULL : auto_duty; // [R6]

	// settings and power-on defaults
	wire full_temp_ok = full_temp_wdata >= FULL_TEMP_MIN && full_temp_wdata <= FULL_TEMP_MAX;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q                  <= ST_SYNC_A;
			full_speed_temperature_q <= FULL_TEMP_RST; // [R9]
			min_speed_threshold_q    <= MIN_RPM_THREE_FAN;
		end else if (ce) begin
			case (state_q)
				// strap needs two edges through its synchroniser before it is valid
				ST_SYNC_A: state_q <= ST_SYNC_B;
				ST_SYNC_B: state_q <= ST_INIT;
				ST_INIT: begin
					state_q <= ST_RUN;
					min_speed_threshold_q <= strap_s2_q ? MIN_RPM_THREE_FAN :
						MIN_RPM_TWO_FAN; // [R5]
				end
				ST_RUN: begin
					if (full_temp_wr && full_temp_ok)
						full_speed_temperature_q <= full_temp_wdata; // [R8]
					if (min_speed_wr)
						min_speed_threshold_q <= min_speed_wdata;
				end
				default: state_q <= ST_INIT;
			endcase
		end
	end

	// pwm: percent counter, one step per prescale
	logic [5:0]        pre_q;
	logic [DUTY_W-1:0] phase_q;
	logic [31:0]       gate_cnt_q;
	wire               pre_wrap   = pre_q == 6'(PWM_PRESCALE - 1);
	wire               phase_wrap = phase_q == DUTY_FULL - 7'h01;
	wire               gate       = gate_cnt_q == 32'(GATE_LEN - 1);
	wire               pwm_on     = phase_q < duty_q; // [R2]

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pre_q      <= '0;
			phase_q    <= '0;
			gate_cnt_q <= '0;
			duty_q     <= DUTY_FULL;
			fan_pwm_q  <= '0;
		end else if (ce) begin
			pre_q      <= pre_wrap ? '0 : pre_q + 6'h01;
			gate_cnt_q <= gate ? '0 : gate_cnt_q + 32'h1;
			if (pre_wrap) begin
				phase_q <= phase_wrap ? '0 : phase_q + 7'h01;
				if (phase_wrap)
					duty_q <= duty_d;
			end
			fan_pwm_q <= {NUM_FANS{pwm_on}};
		end
	end

	// speed measurement per fan
	logic [NUM_FANS-1:0] low_vec, stop_vec;
	generate
		for (gi = 0; gi < NUM_FANS; gi++) begin : g_fan
			fan_tach_meter u_meter (
				.clk       (clk),
				.rstn      (rstn),
				.ce        (ce),
				.tach_sync (tach_s2_q[gi]),
				.gate      (gate),
				.rpm_q     (fan_rpm_q[gi*RPM_W +: RPM_W])
			); // [R1]
			wire used = (gi < 2) || strap_s2_q;
			assign low_vec[gi]  = used && fan_rpm_q[gi*RPM_W +: RPM_W] < min_speed_threshold_q;
			assign stop_vec[gi] = used && fan_rpm_q[gi*RPM_W +: RPM_W] == '0;
		end
	endgenerate

	// first window yields no reading, so hold off checks until one is done
	logic valid_q;
	wire  alarm_d = valid_q && alarm_enable && |low_vec; // [R1] [R12]

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			valid_q          <= 1'b0;
			alarm_q          <= 1'b0;
			alarm_occurred_q <= 1'b0;
			shutdown_q       <= 1'b0;
		end else if (ce) begin
			if (gate && state_q == ST_RUN)
				valid_q <= 1'b1;
			alarm_q <= alarm_d;
			// set wins over clear
			if (alarm_d)
				alarm_occurred_q <= 1'b1; // [R13] [R16]
			else if (alarm_clear)
				alarm_occurred_q <= 1'b0; // [R13]
			if (valid_q && |stop_vec)
				shutdown_q <= 1'b1; // [R14]
		end
	end

	a_high_forces_full: assert property (@(posedge clk) disable iff (!rstn) // [R6]
		ce && high_s2_q && pre_wrap && phase_wrap |=> duty_q == DUTY_FULL)
		else $error("high switch not full duty");
	a_duty_floor: assert property (@(posedge clk) disable iff (!rstn) // [R4]
		duty_q >= DUTY_FLOOR) else $error("duty below floor");
	a_full_at_temp: assert property (@(posedge clk) disable iff (!rstn) // [R3]
		hottest < full_speed_temperature_q && !high_s2_q |-> duty_d < DUTY_FULL)
		else $error("duty full below full-speed temperature");
	a_ramp_start: assert property (@(posedge clk) disable iff (!rstn) // [R10]
		{1'b0, hottest} + {1'b0, RAMP_WIDTH} <= {1'b0, full_speed_temperature_q}
		|-> auto_duty == DUTY_FLOOR)
		else $error("ramp started early");
	a_temp_range: assert property (@(posedge clk) disable iff (!rstn) // [R8]
		full_speed_temperature_q >= FULL_TEMP_MIN && full_speed_temperature_q <= FULL_TEMP_MAX)
		else $error("full-speed temperature out of range");
	a_alarm_latch: assert property (@(posedge clk) disable iff (!rstn) // [R16]
		ce && alarm_d |=> alarm_occurred_q) else $error("alarm flag not latched");
	a_alarm_gate: assert property (@(posedge clk) disable iff (!rstn) // [R12]
		ce && !alarm_enable |=> !alarm_q) else $error("alarm raised while disabled");
	a_alarm_clear: assert property (@(posedge clk) disable iff (!rstn) // [R13]
		ce && alarm_clear && !alarm_d |=> !alarm_occurred_q) else $error("clear ignored");
	a_stop_shutdown: assert property (@(posedge clk) disable iff (!rstn) // [R14]
		ce && valid_q && |stop_vec |=> shutdown_q) else $error("no shutdown on stopped fan");
endmodule

// ===== testbench/fan_sensor_model.sv
`timescale 1ns/1ps
module fan_sensor_model
	import fan_ctrl_pkg::*;
(
	// clock
	input  wire logic                  clk,
	// tach half period per fan in cycles, zero for a stalled rotor
	input  wire logic [NUM_FANS*8-1:0] half_per,
	// tach pulses
	output logic      [NUM_FANS-1:0]   tach
);
	logic [7:0] cnt [NUM_FANS];

	initial begin
		tach = '0;
		for (int i = 0; i < NUM_FANS; i++) cnt[i] = 8'h00;
	end

	always @(posedge clk) begin
		for (int i = 0; i < NUM_FANS; i++) begin
			if (half_per[8*i +: 8] == 8'h00) begin
				// a stopped rotor gives no edges at all
				tach[i] <= 1'b0;
				cnt[i] <= 8'h00;
			end else if (cnt[i] >= half_per[8*i +: 8] - 8'h01) begin
				tach[i] <= ~tach[i];
				cnt[i] <= 8'h00;
			end else begin
				cnt[i] <= cnt[i] + 8'h01;
			end
		end
	end
endmodule

// ===== testbench/fan_speed_control_monitor_tb.sv
`timescale 1ns/1ps
module fan_speed_control_monitor_tb;
	import fan_ctrl_pkg::*;
	logic                          clk = 0, rstn = 0, three_fan = 0, fan_high = 0;
	logic                          full_temp_wr = 0, min_speed_wr = 0;
	logic                          alarm_enable = 1, alarm_clear = 0;
	logic [NUM_SENSORS*TEMP_W-1:0] sensor_temp = '0;
	logic [TEMP_W-1:0]             full_temp_wdata = '0, full_speed_temperature_q;
	logic [RPM_W-1:0]              min_speed_wdata = '0, min_speed_threshold_q;
	logic [NUM_FANS*8-1:0]         half_per = 24'h000A0A;
	logic [NUM_FANS*RPM_W-1:0]     fan_rpm_q;
	logic [NUM_FANS-1:0]           tach_in, fan_pwm_q;
	logic [DUTY_W-1:0]             duty_q;
	logic                          alarm_q, alarm_occurred_q, shutdown_q;
	int                            n_mismatch = 0, compares = 0, hi;
	logic [7:0] tv [8] = '{8'h14, 8'h19, 8'h1E, 8'h28, 8'h31, 8'h32, 8'h50, 8'h2D};
	logic [6:0] dv [8] = '{7'h28, 7'h28, 7'h34, 7'h4C, 7'h61, 7'h64, 7'h64, 7'h34};
	logic [7:0] wv [5] = '{8'h18, 8'h42, 8'h19, 8'h41, 8'h32};
	logic [7:0] ev [5] = '{8'h32, 8'h32, 8'h19, 8'h41, 8'h32};

	always #5 clk = ~clk;

	fan_sensor_model fans_u (.clk, .half_per, .tach(tach_in));

	fan_speed_control_monitor #(.GATE_LEN(1000)) dut_u (.clk, .rstn, .ce(1'b1), .three_fan,
		.fan_high, .sensor_temp, .tach_in, .full_temp_wr, .full_temp_wdata, .min_speed_wr,
		.min_speed_wdata, .alarm_enable, .alarm_clear, .full_speed_temperature_q,
		.min_speed_threshold_q, .fan_rpm_q, .duty_q, .alarm_q, .alarm_occurred_q,
		.shutdown_q, .fan_pwm_q);

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
		end
	endtask

	task automatic wr_full(input logic [7:0] v);
		full_temp_wdata = v;
		full_temp_wr = 1;
		tick(1);
		full_temp_wr = 0;
		tick(1);
	endtask

	task automatic wr_min(input logic [15:0] v);
		min_speed_wdata = v;
		min_speed_wr = 1;
		tick(1);
		min_speed_wr = 0;
		tick(1);
	endtask

	task automatic do_reset(input logic strap);
		three_fan = strap;
		rstn = 0;
		tick(20);
		rstn = 1;
		tick(5);
	endtask

	task automatic duty_case(input int pos, input logic [7:0] t, input logic [6:0] exp);
		sensor_temp = {NUM_SENSORS{8'h0A}};
		sensor_temp[8*pos +: 8] = t;
		tick(4100);
		chk("duty", {9'h000, exp}, {9'h000, duty_q});
	endtask

	task automatic pwm_chk(input logic [15:0] exp);
		hi = 0;
		repeat (4000) begin
			tick(1);
			hi += fan_pwm_q[0];
		end
		chk("pwm_high", exp, hi[15:0]);
	endtask

	task automatic pulse_clear;
		alarm_clear = 1;
		tick(1);
		alarm_clear = 0;
		tick(2);
	endtask

	task automatic tally_and_finish;
		if (n_mismatch == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		tally_and_finish;
	end

	initial begin
		do_reset(1'b0);
		chk("min_thr", 16'h0384, min_speed_threshold_q);
		tick(2100);
		chk("shutdown", 16'h0000, {15'h0000, shutdown_q});
		half_per = 24'h0A0A0A;
		do_reset(1'b1);
		chk("min_thr", 16'h04B0, min_speed_threshold_q);
		chk("full_temp", 16'h0032, {8'h00, full_speed_temperature_q});
		for (int i = 0; i < 5; i++) begin
			wr_full(wv[i]);
			chk("full_temp", {8'h00, ev[i]}, {8'h00, full_speed_temperature_q});
		end
		for (int i = 0; i < 7; i++) duty_case(i, tv[i], dv[i]);
		pwm_chk(16'h0FA0);
		wr_full(8'h41);
		duty_case(7, tv[7], dv[7]);
		fan_high = 1;
		duty_case(2, 8'h14, 7'h64);
		fan_high = 0;
		duty_case(0, 8'h14, 7'h28);
		pwm_chk(16'h0640);
		chk("rpm_ok", 16'h0001, {15'h0000, fan_rpm_q[15:0] inside {[1470:1530]}});
		chk("rpm2_ok", 16'h0001, {15'h0000, fan_rpm_q[47:32] inside {[1470:1530]}});
		chk("alarm", 16'h0000, {15'h0000, alarm_q});
		wr_min(16'h07D0);
		tick(2100);
		chk("alarm", 16'h0001, {15'h0000, alarm_q});
		chk("occurred", 16'h0001, {15'h0000, alarm_occurred_q});
		pulse_clear;
		chk("occurred", 16'h0001, {15'h0000, alarm_occurred_q});
		alarm_enable = 0;
		tick(3);
		chk("alarm", 16'h0000, {15'h0000, alarm_q});
		pulse_clear;
		chk("occurred", 16'h0000, {15'h0000, alarm_occurred_q});
		alarm_enable = 1;
		wr_min(16'h03E8);
		half_per = 24'h0A000A;
		tick(2100);
		chk("shutdown", 16'h0001, {15'h0000, shutdown_q});
		chk("rpm_stop", 16'h0000, fan_rpm_q[31:16]);
		chk("alarm", 16'h0001, {15'h0000, alarm_q});
		tally_and_finish;
	end
endmodule
